// ==== psc_map.svh ====
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
// system clock
`define PSC_CLK_NS 10
// frame length thresholds, in serial clocks
`define PSC_CNT_SHORT 5'd16
`define PSC_CNT_LONG 5'd25
`define PSC_CNT_MAX 5'h1F
`define PSC_OUT_BITS 5'd8
// register map
`define PSC_PAGE_ADDR 5'h1F
`define PSC_PAGE_RST 8'h00
`define PSC_MAIN0_ADDR 5'h00
`define PSC_MAIN1_ADDR 5'h01
`define PSC_LOCK_BIT 0
`define PSC_FOLLOW_BIT 1
`define PSC_PLL_BIT 7
`define PSC_LONG_BIT 7
`define PSC_NPAGES 4
`define PSC_REG_RST 8'h00
// device address that no device answers to
`define PSC_DEV_NONE 2'h3
// host serial clock half period
`define PSC_SCLK_HALF_NS 80
`define PSC_SCLK_HALF (`PSC_SCLK_HALF_NS / `PSC_CLK_NS)
// settle wait after input clock start/stop or software reset
`define PSC_SETTLE_MS 50
`define PSC_SETTLE_CYC (`PSC_SETTLE_MS * 1000000 / `PSC_CLK_NS)
`endif

// ==== psc_pkg.sv ====
`default_nettype none
package psc_pkg;
  // one serial command, in shift order from msb down
  typedef struct packed {
    logic rd;
    logic [1:0] dev;
    logic [4:0] addr;
    logic [7:0] data;
  } psc_cmd_t;

  typedef enum logic [4:0] {
    PSC_IDLE = 5'h01,
    PSC_LEAD = 5'h02,
    PSC_HIGH = 5'h04,
    PSC_LOW = 5'h08,
    PSC_TAIL = 5'h10
  } psc_hstate_t;
endpackage
`default_nettype wire

// ==== psc_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface psc_if;
  logic sclk;
  logic frame_select_n;
  logic serial_in_o;
  logic serial_in_oe;
  logic serial_out_o;
  logic serial_out_oe;
  logic serial_in;
  logic serial_out;

  // undriven lines float high through pull-ups
  assign serial_in = serial_in_oe ? serial_in_o : 1'b1;
  assign serial_out = serial_out_oe ? serial_out_o : 1'b1;

  modport dev (
    input sclk,
    input frame_select_n,
    input serial_in,
    output serial_out_o,
    output serial_out_oe
  );

  modport host (
    output sclk,
    output frame_select_n,
    output serial_in_o,
    output serial_in_oe,
    input serial_out
  );
endinterface
`default_nettype wire

// ==== psc_dev.sv ====
// What this block does
// R1 - short mode needs at least 16 clocks
// R2 - long mode bit needs 25 or more
// R3 - only last 16 bits are processed
// R4 - clockless: reads same, no write readback
// R5 - addressed device drives first eight clocks
// R6 - release output at ninth rising edge
// R7 - host takes input after ninth falling
// R8 - input bits sampled on rising edges
// R9 - write: 0, device, address, value
// R10 - write commits at frame select rise
// R11 - read: 1, device, address, filler
// R12 - read stages data for next frame
// R13 - readback is previously addressed register
// R14 - write readback only with clock running
// R15 - page register at 1Fh, resets 00
// R16 - lock bit starts scanning machines
// R17 - locked: only subset writable
// R18 - host checks pll status before locking
// R19 - leader converts; follower uses line pulses
// R20 - lock zero pauses, reconfigure then
// R21 - host keeps input clock absent or stable
// R22 - chip address pin selects device address
// R23 - host waits 50 ms after clock change
// R24 - frames shift msb first
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.svh"
module psc_dev (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // serial link
  psc_if.dev bus,
  // device strap and status
  input wire logic [1:0] i_chip_addr,
  input wire logic i_pll_locked,
  input wire logic i_input_clock_present,
  input wire logic i_line_start_pulse,
  // scanning control
  output logic o_scan_active,
  output logic o_convert_run,
  output logic o_line_interval,
  output logic o_long_mode
);
  import psc_pkg::*;

  localparam int NREGS = `PSC_NPAGES * 32;

  function automatic logic [6:0] psc_idx(input logic [7:0] page, input logic [4:0] addr);
    psc_idx = {page[1:0], addr};
  endfunction

  // synchronisers: stage 0 feeds stage 1 only
  logic [2:0] sclk_s;
  logic [2:0] sen_s;
  logic [1:0] sin_s;
  logic [1:0] clkp_s;
  logic [2:0] ls_s;
  logic [1:0] chip_s;
  logic [1:0] chip_s0;
  logic [1:0] pll_s;
  logic [1:0] chip_fill_reg;

  logic [7:0] mem [0:NREGS-1];
  logic [7:0] page_reg;
  logic [4:0] cnt_reg;
  logic [15:0] shift_reg;
  logic stage_valid_reg;
  logic [7:0] stage_data_reg;
  logic [7:0] out_reg;
  logic sout_reg;
  logic sout_oe_reg;
  logic [1:0] chip_reg;
  logic chip_done_reg;
  logic convert_reg;
  logic line_reg;

  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sen_fall = ~sen_s[1] & sen_s[2];
  wire sen_rise = sen_s[1] & ~sen_s[2];
  wire in_frame = ~sen_s[1];
  wire ls_rise = ls_s[1] & ~ls_s[2];
  wire clk_present = clkp_s[1];

  wire lock = mem[0][`PSC_LOCK_BIT];
  wire follower = mem[0][`PSC_FOLLOW_BIT];
  wire long_mode = mem[`PSC_MAIN1_ADDR][`PSC_LONG_BIT];
  wire [4:0] min_cnt = long_mode ? `PSC_CNT_LONG : `PSC_CNT_SHORT; // R1 R2
  wire frame_ok = sen_rise & (cnt_reg >= min_cnt); // R1 R2

  // the last 16 bits sampled sit in shift_reg, older bits fell off its top
  wire psc_cmd_t cmd = shift_reg; // R3 R9 R11 R24
  wire [6:0] idx = psc_idx(page_reg, cmd.addr);
  wire page_ok = page_reg < 8'(`PSC_NPAGES);
  wire is_page = cmd.addr == `PSC_PAGE_ADDR;
  wire hit = frame_ok & chip_done_reg & (cmd.dev == chip_reg);
  // while locked only main config 0 and the page register take writes
  wire wr_open = ~lock | (idx == psc_idx(`PSC_PAGE_RST, `PSC_MAIN0_ADDR)); // R17
  wire wr_mem = hit & ~cmd.rd & ~is_page & page_ok & wr_open; // R10
  wire wr_page = hit & ~cmd.rd & is_page; // R15
  wire [7:0] mem_val = page_ok ? mem[idx] : `PSC_REG_RST;
  wire [7:0] pll_val = {pll_s[1], mem_val[6:0]};
  wire is_main0 = page_ok & (idx == psc_idx(`PSC_PAGE_RST, `PSC_MAIN0_ADDR));
  wire [7:0] rd_val = is_page ? page_reg : (is_main0 ? pll_val : mem_val); // R15
  wire [7:0] stage_val = (~cmd.rd & (wr_mem | wr_page)) ? cmd.data : rd_val;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sclk_s <= 3'h0;
      sen_s <= 3'h7;
      sin_s <= 2'h0;
      clkp_s <= 2'h0;
      ls_s <= 3'h0;
      chip_s0 <= 2'h0;
      chip_s <= 2'h0;
      pll_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], bus.sclk};
      sen_s <= {sen_s[1:0], bus.frame_select_n};
      sin_s <= {sin_s[0], bus.serial_in};
      clkp_s <= {clkp_s[0], i_input_clock_present};
      ls_s <= {ls_s[1:0], i_line_start_pulse};
      chip_s0 <= i_chip_addr;
      chip_s <= chip_s0;
      pll_s <= {pll_s[0], i_pll_locked};
    end
  end

  // strap taken once both synchroniser stages hold the pin, not their reset value
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      chip_fill_reg <= 2'h0;
      chip_reg <= `PSC_DEV_NONE;
      chip_done_reg <= 1'b0;
    end else if (!chip_done_reg) begin
      chip_fill_reg <= {chip_fill_reg[0], 1'b1};
      chip_reg <= chip_s; // R22
      chip_done_reg <= chip_fill_reg[1];
    end
  end

  // input shifting and frame length count
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
    end else if (sen_fall) begin
      cnt_reg <= 5'h00;
    end else if (in_frame && sclk_rise) begin
      shift_reg <= {shift_reg[14:0], sin_s[1]}; // R8 R3
      if (cnt_reg != `PSC_CNT_MAX)
        cnt_reg <= cnt_reg + 5'd1;
    end
  end

  // register file; a short or foreign frame leaves it untouched
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < NREGS; i++) begin
        mem[i] <= `PSC_REG_RST;
      end
      page_reg <= `PSC_PAGE_RST; // R15
    end else begin
      if (wr_mem)
        mem[idx] <= cmd.data; // R10 R17
      if (wr_page)
        page_reg <= cmd.data; // R15
    end
  end

  // staging of the readback for the next frame
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stage_valid_reg <= 1'b0;
      stage_data_reg <= `PSC_REG_RST;
    end else if (frame_ok) begin
      // another device addressed: it owns serial_out next frame
      stage_valid_reg <= hit & (cmd.rd | clk_present); // R4 R14
      stage_data_reg <= stage_val; // R12 R13
    end
  end

  // readback shifter: bits launch on rising edges 1 to 8
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      out_reg <= `PSC_REG_RST;
      sout_reg <= 1'b1;
      sout_oe_reg <= 1'b0;
    end else if (sen_fall) begin
      out_reg <= stage_data_reg; // R13
      sout_oe_reg <= 1'b0;
    end else if (!in_frame) begin
      sout_oe_reg <= 1'b0;
    end else if (sclk_rise) begin
      if (cnt_reg < `PSC_OUT_BITS) begin
        sout_oe_reg <= stage_valid_reg; // R5 R14
        sout_reg <= out_reg[7]; // R24
        out_reg <= {out_reg[6:0], 1'b0};
      end else begin
        sout_oe_reg <= 1'b0; // R6
      end
    end
  end

  // scanning: leader converts on lock, follower answers line pulses
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      convert_reg <= 1'b0;
      line_reg <= 1'b0;
    end else begin
      convert_reg <= lock & ~follower; // R16 R19 R20
      line_reg <= lock & follower & ls_rise; // R16 R19
    end
  end

  assign bus.serial_out_o = sout_reg;
  assign bus.serial_out_oe = sout_oe_reg;
  assign o_scan_active = lock; // R16 R20
  assign o_convert_run = convert_reg;
  assign o_line_interval = line_reg;
  assign o_long_mode = long_mode;
endmodule
`default_nettype wire

// ==== psc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.svh"
module psc_host #(
  parameter int SETTLE_CYCLES = `PSC_SETTLE_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // serial link
  psc_if.host bus,
  // command port
  input wire logic i_start,
  input wire psc_pkg::psc_cmd_t i_cmd,
  input wire logic i_long_frame,
  input wire logic i_resync,
  output logic o_ready,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid
);
  import psc_pkg::*;

  // bit of the command due on rising edge k+1 of an n-clock frame
  function automatic logic psc_bit(input logic [15:0] c, input logic [4:0] n,
                                   input logic [4:0] k);
    logic [4:0] pos;
    pos = n - k - 5'd1;
    psc_bit = (pos < 5'd16) ? c[pos[3:0]] : 1'b0;
  endfunction

  psc_hstate_t st_reg;
  logic [3:0] div_reg;
  logic [4:0] k_reg;
  logic [4:0] n_reg;
  logic [15:0] cmd_reg;
  logic sclk_reg;
  logic sen_n_reg;
  logic sin_reg;
  logic sin_oe_reg;
  logic long_reg;
  logic [7:0] rb_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [22:0] settle_reg;
  logic [1:0] so_s;

  wire half_done = div_reg == 4'(`PSC_SCLK_HALF - 1);
  wire settled = settle_reg == 23'h000000;
  wire idle = st_reg == PSC_IDLE;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      so_s <= 2'h3;
      settle_reg <= 23'h000000;
    end else begin
      so_s <= {so_s[0], bus.serial_out};
      // transfers wait out the pll settle time
      if (i_resync)
        settle_reg <= 23'(SETTLE_CYCLES); // R23
      else if (!settled)
        settle_reg <= settle_reg - 23'd1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= PSC_IDLE;
      div_reg <= 4'h0;
      k_reg <= 5'h00;
      n_reg <= `PSC_CNT_SHORT;
      cmd_reg <= 16'h0000;
      sclk_reg <= 1'b0;
      sen_n_reg <= 1'b1;
      sin_reg <= 1'b0;
      sin_oe_reg <= 1'b0;
      long_reg <= 1'b0;
      rb_reg <= 8'h00;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= 1'b0;
      div_reg <= (idle || half_done) ? 4'h0 : div_reg + 4'd1;
      case (st_reg)
        PSC_IDLE: begin
          if (i_start && settled) begin
            cmd_reg <= i_cmd; // R9 R11
            n_reg <= i_long_frame ? `PSC_CNT_LONG : `PSC_CNT_SHORT;
            long_reg <= i_long_frame;
            k_reg <= 5'h00;
            sen_n_reg <= 1'b0;
            sin_reg <= psc_bit(i_cmd, i_long_frame ? `PSC_CNT_LONG : `PSC_CNT_SHORT,
                               5'h00); // R24
            // long frames leave the input line to the readback first
            sin_oe_reg <= ~i_long_frame; // R7
            st_reg <= PSC_LEAD;
          end
        end
        PSC_LEAD, PSC_LOW: begin
          if (half_done) begin
            sclk_reg <= 1'b1; // R8
            k_reg <= k_reg + 5'd1;
            st_reg <= PSC_HIGH;
          end
        end
        PSC_HIGH: begin
          if (half_done) begin
            sclk_reg <= 1'b0;
            if (k_reg <= `PSC_OUT_BITS)
              rb_reg <= {rb_reg[6:0], so_s[1]}; // R5 R24
            if (k_reg == n_reg) begin
              st_reg <= PSC_TAIL;
            end else begin
              sin_reg <= psc_bit(cmd_reg, n_reg, k_reg); // R8
              if (long_reg && k_reg >= `PSC_OUT_BITS + 5'd1)
                sin_oe_reg <= 1'b1; // R7
              st_reg <= PSC_LOW;
            end
          end
        end
        PSC_TAIL: begin
          if (half_done) begin
            sen_n_reg <= 1'b1; // R10 R12
            sin_oe_reg <= 1'b0;
            rdata_reg <= rb_reg; // R13
            rvalid_reg <= 1'b1;
            st_reg <= PSC_IDLE;
          end
        end
        default: begin
          st_reg <= PSC_IDLE;
        end
      endcase
    end
  end

  assign bus.sclk = sclk_reg;
  assign bus.frame_select_n = sen_n_reg;
  assign bus.serial_in_o = sin_reg;
  assign bus.serial_in_oe = sin_oe_reg;
  // software must check pll status and keep the clock stable itself
  assign o_ready = idle & settled; // R18 R21
  assign o_rdata = rdata_reg;
  assign o_rdata_valid = rvalid_reg;
endmodule
`default_nettype wire

// ==== psc_link_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module psc_link_properties (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // link wires
  input wire logic sclk,
  input wire logic frame_select_n,
  input wire logic serial_in_o,
  input wire logic serial_in_oe,
  input wire logic serial_out_o,
  input wire logic serial_out_oe
);
  logic sclk_reg;
  logic [4:0] rise_reg;
  // rising serial clocks seen in the current frame, cleared between frames
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sclk_reg <= 1'b0;
      rise_reg <= 5'h00;
    end else begin
      sclk_reg <= sclk;
      rise_reg <= frame_select_n ? 5'h00 : rise_reg + 5'(sclk & ~sclk_reg);
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_ninth_held;
    (rise_reg == 5'h09) [*6];
  endsequence
  sequence s_out_steady;
    $stable(serial_out_o) [*2];
  endsequence
  property p_release;
    s_ninth_held |-> !serial_out_oe;
  endproperty
  property p_window;
    serial_out_oe |-> rise_reg <= 5'h09;
  endproperty
  property p_first;
    $rose(serial_out_oe) |-> rise_reg inside {[5'h01:5'h08]};
  endproperty
  property p_idle_out;
    frame_select_n [*8] |-> !serial_out_oe;
  endproperty
  property p_out_hold;
    serial_out_oe && $fell(sclk) |-> s_out_steady;
  endproperty
  property p_in_launch;
    serial_in_oe && $changed(serial_in_o) |-> !sclk;
  endproperty
  property p_take;
    $rose(serial_in_oe) && !frame_select_n |-> !sclk && rise_reg inside {5'h00, 5'h09};
  endproperty
  property p_idle_clk;
    frame_select_n |-> !sclk;
  endproperty
  property p_half;
    $changed(sclk) |=> $stable(sclk) [*3];
  endproperty
  property p_gap;
    $rose(frame_select_n) |=> frame_select_n [*2];
  endproperty
  property p_count;
    $rose(frame_select_n) |-> rise_reg == 5'h10 || rise_reg == 5'h19;
  endproperty
  a_release: assert property (p_release) else $error("output held past ninth clock");
  a_window: assert property (p_window) else $error("output driven late in frame");
  a_first: assert property (p_first) else $error("output enabled outside first eight");
  a_idle_out: assert property (p_idle_out) else $error("output driven between frames");
  a_out_hold: assert property (p_out_hold) else $error("output bit moved at falling edge");
  a_in_launch: assert property (p_in_launch) else $error("input bit moved with clock high");
  a_take: assert property (p_take) else $error("input taken at wrong point");
  a_idle_clk: assert property (p_idle_clk) else $error("serial clock high outside frame");
  a_half: assert property (p_half) else $error("serial clock half period short");
  a_gap: assert property (p_gap) else $error("frame gap too short");
  a_count: assert property (p_count) else $error("frame clock count wrong");
endmodule
`default_nettype wire

// ==== paged_serial_config_port_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.svh"
module paged_serial_config_port_tb;
  import psc_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_start = 1'b0;
  psc_cmd_t i_cmd = '0;
  logic i_long_frame = 1'b0;
  logic i_resync = 1'b0;
  logic [1:0] i_chip_addr = 2'h0;
  logic i_pll_locked = 1'b1;
  logic i_input_clock_present = 1'b1;
  logic i_line_start_pulse = 1'b0;
  logic o_ready, o_rdata_valid, o_scan_active, o_convert_run, o_line_interval, o_long_mode;
  logic [7:0] o_rdata;
  // reference register file, page register and staged readback (bit 8: value known)
  logic [7:0] mem [4][32] = '{default: 8'h00};
  logic [7:0] pg = 8'h00;
  logic [8:0] stg = 9'h000;
  logic stg_on = 1'b1;
  logic [8:0] exp_q [$];
  logic [8:0] e_seen;
  int err_total = 0;
  int num_checks = 0;
  int seed = 32'hBD0A;
  int lines = 0;
  psc_if bus_if ();
  psc_host #(.SETTLE_CYCLES(20)) i_psc_host (.i_clk(i_clk), .i_reset(i_reset),
    .bus(bus_if), .i_start(i_start), .i_cmd(i_cmd), .i_long_frame(i_long_frame),
    .i_resync(i_resync), .o_ready(o_ready), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid));
  psc_dev i_psc_dev (.i_clk(i_clk), .i_reset(i_reset), .bus(bus_if),
    .i_chip_addr(i_chip_addr), .i_pll_locked(i_pll_locked),
    .i_input_clock_present(i_input_clock_present), .i_line_start_pulse(i_line_start_pulse),
    .o_scan_active(o_scan_active), .o_convert_run(o_convert_run),
    .o_line_interval(o_line_interval), .o_long_mode(o_long_mode));
  psc_link_properties i_psc_link_properties (.i_clk(i_clk), .i_reset(i_reset),
    .sclk(bus_if.sclk), .frame_select_n(bus_if.frame_select_n),
    .serial_in_o(bus_if.serial_in_o), .serial_in_oe(bus_if.serial_in_oe),
    .serial_out_o(bus_if.serial_out_o), .serial_out_oe(bus_if.serial_out_oe));
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (o_ready !== 1'b1) begin
      @(posedge i_clk);
      n++;
      if (n > 1000) begin
        err_total++;
        print_verdict();
      end
    end
  endtask
  function automatic logic [7:0] rdv(input logic [4:0] a);
    if (a == `PSC_PAGE_ADDR) return pg;
    if (pg == 8'h00 && a == 5'h00) return {i_pll_locked, mem[0][0][6:0]};
    return mem[pg[1:0]][a];
  endfunction
  // one whole frame; the reference model is updated once the commit has landed
  task automatic xfer(input logic rd, input logic [1:0] dv, input logic [4:0] a,
                      input logic [7:0] d, input logic lng);
    logic ok;
    logic wr;
    logic mine;
    ok = lng || !mem[0][1][`PSC_LONG_BIT];
    wr = !mem[0][0][`PSC_LOCK_BIT] || a == `PSC_PAGE_ADDR || (pg == 8'h00 && a == 5'h00);
    mine = dv == i_chip_addr;
    wait_ready();
    exp_q.push_back(stg_on ? stg : 9'h1FF);
    i_cmd <= {rd, dv, a, d};
    i_long_frame <= lng;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    @(posedge i_clk);
    wait_ready();
    repeat (6) @(posedge i_clk);
    if (!ok) return;
    if (!rd && mine && wr && a == `PSC_PAGE_ADDR) pg = d;
    if (!rd && mine && wr && a != `PSC_PAGE_ADDR) mem[pg[1:0]][a] = d;
    // staged copy of a lock register write is the written value, not the live pll bit
    stg = {rd || a != 5'h00 || pg != 8'h00, rdv(a)};
    stg_on = mine && (rd || i_input_clock_present);
  endtask
  always @(negedge i_clk) begin
    if (o_line_interval === 1'b1) lines++;
    if (o_rdata_valid === 1'b1 && exp_q.size() == 0) check(8'h00, 8'h01);
    if (o_rdata_valid === 1'b1 && exp_q.size() > 0) begin
      e_seen = exp_q.pop_front();
      if (e_seen[8]) check(o_rdata, e_seen[7:0]);
    end
  end
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    logic [7:0] v;
    logic [7:0] w;
    v = $random(seed);
    w = $random(seed);
    i_chip_addr <= 2'($unsigned($random(seed)) % 3);
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk);
    xfer(1'b0, i_chip_addr, 5'h02, v, 1'b0);
    xfer(1'b1, i_chip_addr, 5'h02, 8'h00, 1'b0);
    xfer(1'b1, `PSC_DEV_NONE, 5'h02, 8'h00, 1'b0);
    i_input_clock_present <= 1'b0;
    repeat (4) @(posedge i_clk);
    xfer(1'b0, i_chip_addr, 5'h03, w, 1'b0);
    xfer(1'b1, i_chip_addr, 5'h03, 8'h00, 1'b0);
    i_input_clock_present <= 1'b1;
    repeat (4) @(posedge i_clk);
    xfer(1'b0, i_chip_addr, `PSC_PAGE_ADDR, 8'h01, 1'b0);
    xfer(1'b0, i_chip_addr, 5'h02, ~v, 1'b0);
    xfer(1'b1, i_chip_addr, `PSC_PAGE_ADDR, 8'h00, 1'b0);
    xfer(1'b0, i_chip_addr, `PSC_PAGE_ADDR, 8'h00, 1'b0);
    xfer(1'b1, i_chip_addr, 5'h02, 8'h00, 1'b0);
    xfer(1'b0, i_chip_addr, 5'h01, 8'h80, 1'b0);
    check({7'h00, o_long_mode}, 8'h01);
    xfer(1'b0, i_chip_addr, 5'h02, 8'h00, 1'b0);
    xfer(1'b1, i_chip_addr, 5'h02, 8'h00, 1'b1);
    // pll status read before locking; its value comes back in the lock frame
    xfer(1'b1, i_chip_addr, 5'h00, 8'h00, 1'b1);
    xfer(1'b0, i_chip_addr, 5'h00, 8'h01, 1'b1);
    check({6'h00, o_scan_active, o_convert_run}, 8'h03);
    xfer(1'b0, i_chip_addr, 5'h02, 8'h00, 1'b1);
    xfer(1'b1, i_chip_addr, 5'h02, 8'h00, 1'b1);
    xfer(1'b0, i_chip_addr, 5'h00, 8'h03, 1'b1);
    check({7'h00, o_convert_run}, 8'h00);
    repeat (3) begin
      i_line_start_pulse <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_line_start_pulse <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
    repeat (8) @(posedge i_clk);
    check(8'(lines), 8'h03);
    xfer(1'b0, i_chip_addr, 5'h00, 8'h00, 1'b1);
    check({7'h00, o_scan_active}, 8'h00);
    xfer(1'b1, i_chip_addr, 5'h01, 8'h00, 1'b1);
    i_resync <= 1'b1;
    @(posedge i_clk);
    i_resync <= 1'b0;
    @(posedge i_clk);
    check({7'h00, o_ready}, 8'h00);
    xfer(1'b1, i_chip_addr, 5'h02, 8'h00, 1'b1);
    wait_ready();
    print_verdict();
  end
endmodule
`default_nettype wire
